//--- common/ccs_pkg.sv
package ccs_pkg;

  typedef enum logic [4:0] {
    CCS_IDLE  = 5'b0_0001,
    CCS_PRE   = 5'b0_0010,
    CCS_FAST  = 5'b0_0100,
    CCS_DONE  = 5'b0_1000,
    CCS_FAULT = 5'b1_0000
  } ccs_chg_t;

  typedef enum logic [3:0] {
    CCS_PP_BATT    = 4'b0001,
    CCS_PP_TO_AC   = 4'b0010,
    CCS_PP_AC      = 4'b0100,
    CCS_PP_TO_BATT = 4'b1000
  } ccs_path_t;

  // Comparator and pin flags, all active high
  typedef struct packed {
    logic charge_enable;
    logic undervoltage_lockout;
    logic supply_low_state;
    logic input_overvoltage;
    logic supply_above_batt;
    logic supply_near_batt;
    logic ldo_good;
    logic die_over_temp;
    logic batt_temp_fault;
    logic above_precharge_exit;
    logic above_recharge;
    logic below_termination;
    logic input_over_limit;
    logic timer_cap_low;
    logic timer_cap_ref;
  } ccs_pins_t;

  typedef struct packed {
    logic       adapter_switch_drive;
    logic       battery_switch_drive;
    logic       charger_on;
    logic       fast_select;
    logic [3:0] current_step;
    logic       input_power_limit;
    logic       sleep;
    logic       fault;
    logic       charge_done;
  } ccs_cmd_t;

endpackage

//--- common/ccs_regs.svh
// Notes on behaviour
// - With battery below precharge exit level at start, apply precharge current.
// - Precharge lasting 30 minutes without exit turns charger off with fault.
// - In voltage phase with timer pin valid, terminate on high feedback, low current.
// - Safety time is cap value times 5.6 minutes per nF, 10 to 110 nF.
// - Recharge drop, power-on reset or enable toggle start new cycle, reset timer.
// - Timer pin low disables termination and safety timer, holding it reset.
// - Timer pin at reference keeps termination but disables safety timer.
// - Safety timer resets when overvoltage, supply-low or sleep returns to normal.
// - Supply above battery: adapter switch on, battery off, then try charging.
// - Battery above supply: battery switch on and enter sleep; code sets sleep but keeps CCS_PP_AC until leave_ac.
// - Under lockout the device is off, adapter switch off, battery switch on.
// - Charging needs enable, awake, no overvoltage, 30 ms delay, LDOs, temps fine.
// - Charging stops on any enable condition lost or safety timer expiry.
// - In power up, sleep or no adapter, battery feeds the system; in CCS_PP_AC the code ignores sleep and keeps the adapter until leave_ac.
// - About 30 ms after leaving sleep, swap battery switch for adapter switch.
// - Every changeover holds both switches off 10 us first.
// - After adapter removal, return to battery once supply within 200 mV.
// - Each fast-charge entry ramps setpoint in eight steps of 1.6 ms.
// - Input current above limit lowers the charge current target.
// - Fast target is setpoint over 20 times sense resistance, 100 mV full scale.
// - Precharge and termination target is setpoint over 100 times, 125 mA minimum.
// - Input limit is setpoint over 20 times input sense resistance, 0 to 2 V.
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CCS_CLK_NS          5
`define CCS_TENTH_MIN_MS    6000
`define CCS_POWERUP_MS      30
`define CCS_DEAD_NS         10000
`define CCS_STEP_US         1600
`define CCS_PRE_LIMIT_MIN   30
`define CCS_TTC_TENTHS_NF   56
`define CCS_DEAD_CYC        (`CCS_DEAD_NS / `CCS_CLK_NS)
`define CCS_SS_STEPS        4'h8

// ****************************************************************
// Analog scaling of setpoints
// ****************************************************************
`define CCS_FAST_GAIN       20
`define CCS_PRE_GAIN        100
`define CCS_DPM_GAIN        20
`define CCS_SENSE_FS_MV     100
`define CCS_SETPOINT_FS_MV  2000
`define CCS_PRE_MIN_MA      125

// ****************************************************************
// Register map
// ****************************************************************
`define CCS_ADDR_TTC        8'h00
`define CCS_ADDR_STATUS     8'h04
`define CCS_ADDR_TIMER      8'h08
`define CCS_TTC_RESET       7'h0a
`define CCS_TTC_MIN         7'h0a
`define CCS_TTC_MAX         7'h6e
`define CCS_RESP_OKAY       2'h0
`define CCS_RESP_SLVERR     2'h2

`endif

//--- rtl/ccs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"

module ccs_top #(
  parameter int unsigned TENTH_MIN_CYC = `CCS_TENTH_MIN_MS * (1000000 / `CCS_CLK_NS),
  parameter int unsigned DELAY_CYC     = `CCS_POWERUP_MS * (1000000 / `CCS_CLK_NS),
  parameter int unsigned STEP_CYC      = `CCS_STEP_US * (1000 / `CCS_CLK_NS)
) (
  input  wire logic              aclk,          // 200 MHz clock
  input  wire logic              aresetn,       // Synchronous reset, low
  input  wire ccs_pkg::ccs_pins_t pins_async,   // Comparator flags, unsynced
  output var  ccs_pkg::ccs_cmd_t  cmd,          // Switch and charger commands
  input  wire logic [7:0]        s_axi_awaddr,  // Write address
  input  wire logic              s_axi_awvalid, // Write address valid
  output logic                   s_axi_awready, // Write address ready
  input  wire logic [31:0]       s_axi_wdata,   // Write data
  input  wire logic [3:0]        s_axi_wstrb,   // Write strobes
  input  wire logic              s_axi_wvalid,  // Write data valid
  output logic                   s_axi_wready,  // Write data ready
  output logic [1:0]             s_axi_bresp,   // Write response
  output logic                   s_axi_bvalid,  // Write response valid
  input  wire logic              s_axi_bready,  // Write response ready
  input  wire logic [7:0]        s_axi_araddr,  // Read address
  input  wire logic              s_axi_arvalid, // Read address valid
  output logic                   s_axi_arready, // Read address ready
  output logic [31:0]            s_axi_rdata,   // Read data
  output logic [1:0]             s_axi_rresp,   // Read response
  output logic                   s_axi_rvalid,  // Read data valid
  input  wire logic              s_axi_rready   // Read data ready
);
  import ccs_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  ccs_pins_t pins_meta_reg;
  ccs_pins_t pins_reg;
  ccs_pins_t pins_last_reg;

  always_ff @(posedge aclk)
  begin
    pins_meta_reg <= pins_async;
    pins_reg      <= pins_meta_reg;
    pins_last_reg <= pins_reg;
  end

  logic sleep_now;
  logic timer_run_ok;
  logic term_ok;
  assign sleep_now    = !pins_reg.supply_above_batt;
  assign timer_run_ok = !pins_reg.timer_cap_low && !pins_reg.timer_cap_ref;
  assign term_ok      = !pins_reg.timer_cap_low;

  // ****************************************************************
  // Power-up and wake delay
  // ****************************************************************
  logic [31:0] wake_cnt_reg;
  logic        wake_done_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || sleep_now || pins_reg.undervoltage_lockout)
    begin
      wake_cnt_reg  <= 32'h0000_0000;
      wake_done_reg <= 1'b0;
    end
    else if (wake_cnt_reg == DELAY_CYC - 1)
      wake_done_reg <= 1'b1;
    else
      wake_cnt_reg <= wake_cnt_reg + 32'h0000_0001;
  end

  // ****************************************************************
  // Power path selector
  // ****************************************************************
  ccs_path_t   path_reg;
  logic [15:0] dead_cnt_reg;
  logic        want_ac;
  logic        leave_ac;

  assign want_ac  = !pins_reg.undervoltage_lockout && !sleep_now && wake_done_reg &&
                    !pins_reg.input_overvoltage;
  assign leave_ac = pins_reg.undervoltage_lockout || pins_reg.input_overvoltage ||
                    pins_reg.supply_near_batt;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      path_reg     <= CCS_PP_BATT;
      dead_cnt_reg <= 16'h0000;
    end
    else
    begin
      case (path_reg)
        CCS_PP_BATT:
        begin
          dead_cnt_reg <= 16'h0000;
          if (want_ac)
            path_reg <= CCS_PP_TO_AC;
        end
        CCS_PP_TO_AC:
        begin
          dead_cnt_reg <= dead_cnt_reg + 16'h0001;
          if (leave_ac || sleep_now)
          begin
            path_reg     <= CCS_PP_TO_BATT;
            dead_cnt_reg <= 16'h0000;
          end
          else if (dead_cnt_reg == 16'(`CCS_DEAD_CYC - 1))
            path_reg <= CCS_PP_AC;
        end
        CCS_PP_AC:
        begin
          dead_cnt_reg <= 16'h0000;
          if (leave_ac)
            path_reg <= CCS_PP_TO_BATT;
        end
        CCS_PP_TO_BATT:
        begin
          dead_cnt_reg <= dead_cnt_reg + 16'h0001;
          if (dead_cnt_reg == 16'(`CCS_DEAD_CYC - 1))
            path_reg <= CCS_PP_BATT;
        end
        default:
          path_reg <= CCS_PP_BATT;
      endcase
    end
  end

  // ****************************************************************
  // Enable conditions and new-cycle triggers
  // ****************************************************************
  logic chg_allow;
  logic ce_toggle;
  logic resume_normal;
  logic por_reg;

  assign chg_allow = pins_reg.charge_enable && !pins_reg.undervoltage_lockout &&
                     !pins_reg.supply_low_state && !sleep_now &&
                     !pins_reg.input_overvoltage && wake_done_reg &&
                     pins_reg.ldo_good && !pins_reg.die_over_temp &&
                     !pins_reg.batt_temp_fault && path_reg == CCS_PP_AC;
  assign ce_toggle = pins_reg.charge_enable != pins_last_reg.charge_enable;
  assign resume_normal = (pins_last_reg.input_overvoltage && !pins_reg.input_overvoltage) ||
                         (pins_last_reg.supply_low_state && !pins_reg.supply_low_state) ||
                         (!pins_last_reg.supply_above_batt && pins_reg.supply_above_batt);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      por_reg <= 1'b1;
    else
      por_reg <= 1'b0;
  end

  // ****************************************************************
  // Charge state machine
  // ****************************************************************
  ccs_chg_t chg_reg;
  logic     new_cycle;
  logic     pre_expired;
  logic     safety_expired;

  assign new_cycle = por_reg || ce_toggle ||
                     (chg_reg == CCS_DONE && !pins_reg.above_recharge);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      chg_reg <= CCS_IDLE;
    else if (new_cycle)
      chg_reg <= CCS_IDLE;
    else
    begin
      case (chg_reg)
        CCS_IDLE:
          if (chg_allow)
            chg_reg <= pins_reg.above_precharge_exit ? CCS_FAST : CCS_PRE;
        CCS_PRE:
          if (!chg_allow)
            chg_reg <= CCS_IDLE;
          else if (pre_expired)
            chg_reg <= CCS_FAULT;
          else if (pins_reg.above_precharge_exit)
            chg_reg <= CCS_FAST;
        CCS_FAST:
          if (!chg_allow)
            chg_reg <= CCS_IDLE;
          else if (safety_expired)
            chg_reg <= CCS_FAULT;
          else if (term_ok && pins_reg.above_recharge && pins_reg.below_termination)
            chg_reg <= CCS_DONE;
        CCS_DONE:
          if (!chg_allow)
            chg_reg <= CCS_IDLE;
        CCS_FAULT:
          chg_reg <= CCS_FAULT;
        default:
          chg_reg <= CCS_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Safety and precharge timers
  // ****************************************************************
  logic [6:0]  ttc_nf_reg;
  logic [31:0] tick_cnt_reg;
  logic        tick_reg;
  logic [15:0] safety_cnt_reg;
  logic [8:0]  pre_cnt_reg;
  logic [15:0] safety_limit;
  logic        charging;

  assign charging       = chg_reg == CCS_PRE || chg_reg == CCS_FAST;
  assign safety_limit   = 16'(ttc_nf_reg * `CCS_TTC_TENTHS_NF);
  assign safety_expired = timer_run_ok && safety_cnt_reg >= safety_limit;
  assign pre_expired    = pre_cnt_reg >= 9'(`CCS_PRE_LIMIT_MIN * 10);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !charging)
    begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
    end
    else if (tick_cnt_reg == TENTH_MIN_CYC - 1)
    begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      tick_reg     <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || new_cycle || resume_normal || !timer_run_ok)
      safety_cnt_reg <= 16'h0000;
    else if (tick_reg && charging && !safety_expired)
      safety_cnt_reg <= safety_cnt_reg + 16'h0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || chg_reg != CCS_PRE)
      pre_cnt_reg <= 9'h000;
    else if (tick_reg && !pre_expired)
      pre_cnt_reg <= pre_cnt_reg + 9'h001;
  end

  // ****************************************************************
  // Soft start of fast-charge setpoint
  // ****************************************************************
  logic [3:0]  step_reg;
  logic [31:0] step_cnt_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || chg_reg != CCS_FAST)
    begin
      step_reg     <= 4'h0;
      step_cnt_reg <= 32'h0000_0000;
    end
    else if (step_reg == 4'h0)
      step_reg <= 4'h1;
    else if (step_reg != `CCS_SS_STEPS)
    begin
      if (step_cnt_reg == STEP_CYC - 1)
      begin
        step_cnt_reg <= 32'h0000_0000;
        step_reg     <= step_reg + 4'h1;
      end
      else
        step_cnt_reg <= step_cnt_reg + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // Command outputs
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd <= '0;
      cmd.battery_switch_drive <= 1'b1;
    end
    else
    begin
      cmd.adapter_switch_drive <= path_reg == CCS_PP_AC;
      cmd.battery_switch_drive <= path_reg == CCS_PP_BATT;
      cmd.charger_on           <= charging && chg_allow;
      cmd.fast_select          <= chg_reg == CCS_FAST;
      cmd.current_step         <= step_reg;
      cmd.input_power_limit    <= charging && pins_reg.input_over_limit;
      cmd.sleep                <= sleep_now;
      cmd.fault                <= chg_reg == CCS_FAULT;
      cmd.charge_done          <= chg_reg == CCS_DONE;
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  logic [7:0] aw_addr_reg;
  logic [7:0] w_strb_pad;
  logic [6:0] w_data_reg;
  logic       w_lane0_reg;
  logic       aw_got_reg;
  logic       w_got_reg;

  assign w_strb_pad = {4'h0, s_axi_wstrb};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CCS_RESP_OKAY;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 7'h00;
      w_lane0_reg   <= 1'b0;
      ttc_nf_reg    <= `CCS_TTC_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_reg   <= s_axi_awaddr;
        aw_got_reg    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_reg   <= s_axi_wdata[6:0];
        w_lane0_reg  <= w_strb_pad[0];
        w_got_reg    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_got_reg && w_got_reg && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg == `CCS_ADDR_TTC)
        begin
          s_axi_bresp <= `CCS_RESP_OKAY;
          if (w_lane0_reg && w_data_reg >= `CCS_TTC_MIN && w_data_reg <= `CCS_TTC_MAX)
            ttc_nf_reg <= w_data_reg;
        end
        else if (aw_addr_reg == `CCS_ADDR_STATUS || aw_addr_reg == `CCS_ADDR_TIMER)
          s_axi_bresp <= `CCS_RESP_OKAY;
        else
          s_axi_bresp <= `CCS_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_got_reg    <= 1'b0;
        w_got_reg     <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  logic [31:0] status_word;
  assign status_word = {13'h0000, path_reg, chg_reg, wake_done_reg, sleep_now,
                        cmd.adapter_switch_drive, cmd.battery_switch_drive,
                        cmd.current_step, cmd.fault, cmd.charge_done};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CCS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `CCS_RESP_OKAY;
      if (s_axi_araddr == `CCS_ADDR_TTC)
        s_axi_rdata <= {25'h000_0000, ttc_nf_reg};
      else if (s_axi_araddr == `CCS_ADDR_STATUS)
        s_axi_rdata <= status_word;
      else if (s_axi_araddr == `CCS_ADDR_TIMER)
        s_axi_rdata <= {safety_cnt_reg, 7'h00, pre_cnt_reg};
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `CCS_RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

//--- testbench/ccs_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Power path, charge and bus checks
// ****
module ccs_sva #(
  parameter int unsigned TENTH_MIN_CYC = 10,
  parameter int unsigned DELAY_CYC     = 50,
  parameter int unsigned STEP_CYC      = 8
) (
  input wire logic               aclk,          // Clock
  input wire logic               aresetn,       // Reset, low
  input wire ccs_pkg::ccs_pins_t pins_async,    // Flags
  input wire ccs_pkg::ccs_cmd_t  cmd,           // Commands
  input wire logic               s_axi_arready, // Read address ready
  input wire logic               s_axi_rvalid   // Read data valid
);
  import ccs_pkg::*;
  logic [15:0] off_cnt;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Cycles with both switches off
  always_ff @(posedge aclk)
    if (!aresetn || cmd.adapter_switch_drive || cmd.battery_switch_drive)
      off_cnt <= 16'h0000;
    else if (off_cnt != 16'hffff)
      off_cnt <= off_cnt + 16'h0001;
  sequence ce_drop;
    $fell(pins_async.charge_enable);
  endsequence
  sequence undervoltage_lockout_held;
    pins_async.undervoltage_lockout [*6];
  endsequence
  sequence step_up;
    $changed(cmd.current_step) && cmd.current_step != 4'h0 && cmd.current_step != 4'h8;
  endsequence
  switch_excl_a: assert property (!(cmd.adapter_switch_drive && cmd.battery_switch_drive))
    else $error("both switches on");
  dead_time_a: assert property (
    ($rose(cmd.adapter_switch_drive) || $rose(cmd.battery_switch_drive)) |-> off_cnt >= 16'h07c6)
    else $error("dead time too short");
  step_hold_a: assert property (
    step_up |=> ($stable(cmd.current_step) || cmd.current_step == 4'h0) [*7])
    else $error("soft start step too short");
  step_inc_a: assert property (
    $changed(cmd.current_step) && $past(cmd.current_step) != 4'h0 && cmd.current_step != 4'h0
    |-> cmd.current_step == $past(cmd.current_step) + 4'h1 && cmd.current_step <= 4'h8)
    else $error("soft start step skipped");
  chg_needs_ac_a: assert property (cmd.charger_on |-> cmd.adapter_switch_drive)
    else $error("charging without adapter");
  fault_off_a: assert property (cmd.fault |-> !cmd.charger_on)
    else $error("charging in fault");
  done_off_a: assert property (cmd.charge_done |-> !cmd.charger_on)
    else $error("charging after termination");
  ce_stop_a: assert property (ce_drop |-> ##[1:5] !cmd.charger_on)
    else $error("enable low did not stop charging");
  undervoltage_lockout_off_a: assert property (
    undervoltage_lockout_held |-> !cmd.adapter_switch_drive && !cmd.charger_on)
    else $error("lockout left adapter on");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
endmodule

bind ccs_top ccs_sva #(
  .TENTH_MIN_CYC(TENTH_MIN_CYC), .DELAY_CYC(DELAY_CYC), .STEP_CYC(STEP_CYC)
) u_sva (.aclk, .aresetn, .pins_async, .cmd, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Charger sequencer bench
// ****
module tb;
  import ccs_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] rs;} ccs_row_t;
  localparam int TM = 10;
  localparam int SAFE = 10 * 56 * TM;
  localparam int PREL = 300 * TM;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  ccs_pins_t   pins_async = 15'h4300;
  ccs_cmd_t    cmd;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_bresp;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        s_axi_awready;
  logic        s_axi_wready;
  logic        s_axi_bvalid;
  logic        s_axi_arready;
  logic        s_axi_rvalid;
  int          failures = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          n;
  logic [1:0]  r;
  logic [31:0] d;
  logic [14:0] stops [5] = '{15'h0080, 15'h0040, 15'h0100, 15'h4000, 15'h0800};
  ccs_row_t    rows [10] = '{
    '{1'h0, 8'h00, 32'h0000_000a, 2'h0}, '{1'h1, 8'h00, 32'h0000_0014, 2'h0},
    '{1'h0, 8'h00, 32'h0000_0014, 2'h0}, '{1'h1, 8'h00, 32'h0000_006f, 2'h0},
    '{1'h0, 8'h00, 32'h0000_0014, 2'h0}, '{1'h1, 8'h00, 32'h0000_006e, 2'h0},
    '{1'h0, 8'h00, 32'h0000_006e, 2'h0}, '{1'h1, 8'h04, 32'hffff_ffff, 2'h0},
    '{1'h1, 8'h00, 32'h0000_000a, 2'h0}, '{1'h0, 8'h0c, 32'h0000_0000, 2'h2}};

  ccs_top #(.TENTH_MIN_CYC(TM), .DELAY_CYC(50), .STEP_CYC(8)) DUT (
    .aclk, .aresetn, .pins_async, .cmd, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  always #2.5 aclk = ~aclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic wait_bit(input int b, input logic v, input int lim);
    n = 0;
    while (cmd[b] !== v && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    check(cmd, 32'h0000_0400);
    check({s_axi_awready, s_axi_wready, s_axi_arready}, 32'h0000_0007);
    $display("test reset done");
    foreach (rows[i])
    begin
      if (rows[i].wr)
        axi_wr(rows[i].a, rows[i].d, r);
      else
      begin
        axi_rd(rows[i].a, d, r);
        check(d, rows[i].d);
      end
      check(r, rows[i].rs);
    end
    $display("test registers done");
    check(cmd.sleep, 1'h1);
    pins_async.supply_above_batt <= 1'h1;
    pins_async.supply_near_batt <= 1'h0;
    wait_bit(10, 1'h0, 400);
    check(n >= 50 && n < 60, 1'h1);
    wait_bit(11, 1'h1, 2500);
    check(n >= 1995 && n < 2005, 1'h1);
    check(cmd.battery_switch_drive, 1'h0);
    wait_bit(9, 1'h1, 20);
    check(cmd.fast_select, 1'h0);
    pins_async.above_precharge_exit <= 1'h1;
    for (int k = 1; k <= 8; k++)
    begin
      n = 0;
      while (cmd.current_step !== 4'(k) && n < 20)
      begin
        @(posedge aclk);
        n++;
      end
      check(cmd.current_step, k);
    end
    $display("test power path done");
    foreach (stops[i])
    begin
      pins_async <= pins_async ^ stops[i];
      repeat (6) @(posedge aclk);
      check(cmd.charger_on, 1'h0);
      pins_async <= pins_async ^ stops[i];
      wait_bit(9, 1'h1, 4500);
      check(cmd.charger_on, 1'h1);
    end
    pins_async.input_over_limit <= 1'h1;
    repeat (5) @(posedge aclk);
    check(cmd.input_power_limit, 1'h1);
    pins_async.input_over_limit <= 1'h0;
    pins_async.timer_cap_low <= 1'h1;
    pins_async.above_recharge <= 1'h1;
    pins_async.below_termination <= 1'h1;
    repeat (20) @(posedge aclk);
    check(cmd.charge_done, 1'h0);
    pins_async.timer_cap_low <= 1'h0;
    wait_bit(0, 1'h1, 10);
    check({cmd.charge_done, cmd.charger_on}, 32'h0000_0002);
    pins_async.above_recharge <= 1'h0;
    pins_async.below_termination <= 1'h0;
    wait_bit(8, 1'h1, 20);
    // First step follows the fast select by one cycle
    @(posedge aclk);
    check(cmd.current_step, 32'h0000_0001);
    wait_bit(1, 1'h1, 6000);
    check(n >= SAFE && n < SAFE + 10, 1'h1);
    $display("test charge cycle done");
    pins_async.charge_enable <= 1'h0;
    repeat (6) @(posedge aclk);
    pins_async.charge_enable <= 1'h1;
    pins_async.above_precharge_exit <= 1'h0;
    pins_async.timer_cap_ref <= 1'h1;
    wait_bit(9, 1'h1, 50);
    check(cmd.fault, 1'h0);
    wait_bit(1, 1'h1, 3200);
    check(n >= PREL && n < PREL + 10, 1'h1);
    pins_async.undervoltage_lockout <= 1'h1;
    wait_bit(10, 1'h1, 2200);
    check(cmd.adapter_switch_drive, 1'h0);
    check(n >= 2000 && n < 2010, 1'h1);
    $display("test faults done");
    summarize();
  end
endmodule
`default_nettype wire
